// ===== design/sgdc_dispatcher.sv
// Purpose: dispatcher control, fill levels and response reporting
// Assumes: hosts and data sink run on clk; agent reads answer one cycle later
// Notes: each accepted descriptor enters both the read and write queues

`timescale 1ns/100ps

// Behaviour
// - busy while queued, transferring or awaiting responses
// - stop-descriptors bit halts issue; stopped when idle
// - interrupt enable gates events before latching
// - stop on early termination halts issue
// - stop on error beat halts issue
// - software reset flushes, holds until hosts idle
// - manual stop; stopped only after hosts finish
// - runs after reset with no setup
// - reading byte seven pops one response
// - full response queue withholds all commands
// - byte count from start to end packet
// - early-terminated unaligned count may overcount
// - error bits accumulate until transfer completes
// - early termination when count exceeds length
// - early termination sits at bit eight
// - write queue fill level, sixteen bits
// - read queue fill level, sixteen bits
module sgdc_dispatcher
  import sgdc_pkg::*;
#(
  parameter int unsigned CMD_DEPTH = 8,
  parameter int unsigned RESP_DEPTH = 8,
  parameter int unsigned BYTES_W = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control agent
  input wire logic [3:0] csr_address,
  input wire logic csr_read,
  input wire logic csr_write,
  input wire logic [DATA_W-1:0] csr_writedata,
  output logic [DATA_W-1:0] csr_readdata,
  // response agent
  input wire logic [2:0] resp_address,
  input wire logic resp_read,
  input wire logic [3:0] resp_byteenable,
  output logic [DATA_W-1:0] resp_readdata,
  // descriptor intake
  input wire logic desc_valid,
  output logic desc_ready,
  input wire logic [LEN_W-1:0] desc_length,
  input wire logic desc_wait_resp,
  // read host
  output logic rd_cmd_valid,
  input wire logic rd_cmd_ready,
  output logic [LEN_W-1:0] rd_cmd_length,
  input wire logic rd_busy,
  // write host
  output logic wr_cmd_valid,
  input wire logic wr_cmd_ready,
  output logic [LEN_W-1:0] wr_cmd_length,
  input wire logic wr_busy,
  input wire logic wr_resp_pending,
  // write host data sink, observed
  input wire logic snk_valid,
  input wire logic snk_ready,
  input wire logic snk_sop,
  input wire logic snk_eop,
  input wire logic [BYTES_W-1:0] snk_bytes,
  input wire logic [ERR_W-1:0] snk_error,
  // system
  output logic hosts_reset,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic irq;
    logic err_stop;
    logic et_stop;
    logic resetting;
    logic [LEN_W-1:0] bcnt;
    logic [ERR_W-1:0] errs;
    logic [LEN_W-1:0] cur_len;
    logic cur_wait;
    logic [DATA_W-1:0] csr_rdata;
    logic [DATA_W-1:0] resp_rdata;
  } sgdc_state_t;

  sgdc_state_t s_q;
  sgdc_state_t s_d;

  sgdc_fifo_if #(.W(LEN_W)) rdq ();
  sgdc_fifo_if #(.W(LEN_W + 1)) wrq ();
  sgdc_fifo_if #(.W(RESP_W)) rspq ();

  // ****************************************
  // queues
  // ****************************************
  sgdc_fifo #(.W(LEN_W), .DEPTH(CMD_DEPTH)) u_rd_queue (
    .clk(clk),
    .arst_n(arst_n),
    .f(rdq.store)
  );

  sgdc_fifo #(.W(LEN_W + 1), .DEPTH(CMD_DEPTH)) u_wr_queue (
    .clk(clk),
    .arst_n(arst_n),
    .f(wrq.store)
  );

  sgdc_fifo #(.W(RESP_W), .DEPTH(RESP_DEPTH)) u_resp_queue (
    .clk(clk),
    .arst_n(arst_n),
    .f(rspq.store)
  );

  // ****************************************
  // issue and status terms
  // ****************************************
  logic issue_en;
  logic stop_req;
  logic hosts_idle;
  logic busy;
  logic stopped;
  logic beat;
  logic [LEN_W-1:0] cnt_next;
  logic [ERR_W-1:0] errs_next;
  logic over_len;
  logic resp_done;
  logic resp_et;
  logic pop_resp;
  logic [DATA_W-1:0] status_word;

  assign stop_req = s_q.ctrl[CTRL_STOP] || s_q.ctrl[CTRL_STOP_DESC]
    || s_q.err_stop || s_q.et_stop;
  assign issue_en = !stop_req && !rspq.full && !s_q.resetting;
  assign hosts_idle = !rd_busy && !wr_busy && !wr_resp_pending;
  assign stopped = stop_req && !rd_busy && !wr_busy;
  assign busy = !rdq.empty || !wrq.empty || rd_busy || wr_busy
    || (wr_resp_pending && s_q.cur_wait);

  assign desc_ready = !rdq.full && !wrq.full && !s_q.resetting;
  assign rdq.push = desc_valid && desc_ready;
  assign rdq.wdata = desc_length;
  assign wrq.push = desc_valid && desc_ready;
  assign wrq.wdata = {desc_wait_resp, desc_length};

  assign rd_cmd_valid = issue_en && !rdq.empty;
  assign rd_cmd_length = rdq.rdata;
  assign rdq.pop = rd_cmd_valid && rd_cmd_ready;
  assign wr_cmd_valid = issue_en && !wrq.empty;
  assign wr_cmd_length = wrq.rdata[LEN_W-1:0];
  assign wrq.pop = wr_cmd_valid && wr_cmd_ready;

  assign rdq.clear = s_q.resetting;
  assign wrq.clear = s_q.resetting;
  assign rspq.clear = s_q.resetting;
  assign hosts_reset = s_q.resetting;
  assign irq = s_q.irq;
  assign csr_readdata = s_q.csr_rdata;
  assign resp_readdata = s_q.resp_rdata;

  // ****************************************
  // packet accounting
  // ****************************************
  assign beat = snk_valid && snk_ready && !s_q.resetting;
  // start of packet restarts the count, later beats add on
  assign cnt_next = (snk_sop ? '0 : s_q.bcnt) + LEN_W'(snk_bytes);
  assign errs_next = (snk_sop ? '0 : s_q.errs) | snk_error;
  assign over_len = cnt_next > s_q.cur_len;
  assign resp_done = beat && (snk_eop || over_len);
  assign resp_et = !snk_eop && over_len;
  // on early termination the last beat is still counted whole
  assign rspq.push = resp_done;
  assign rspq.wdata = {resp_et, errs_next, cnt_next};

  assign pop_resp = resp_read && (resp_address == RESP_ERR_OFS)
    && resp_byteenable[RESP_POP_LANE];
  assign rspq.pop = pop_resp;

  always_comb
  begin
    status_word = '0;
    status_word[ST_BUSY] = busy;
    status_word[ST_DESC_EMPTY] = rdq.empty && wrq.empty;
    status_word[ST_DESC_FULL] = rdq.full || wrq.full;
    status_word[ST_RESP_EMPTY] = rspq.empty;
    status_word[ST_RESP_FULL] = rspq.full;
    status_word[ST_STOPPED] = stopped;
    status_word[ST_RESETTING] = s_q.resetting;
    status_word[ST_STOP_ERR] = s_q.err_stop;
    status_word[ST_STOP_ET] = s_q.et_stop;
    status_word[ST_IRQ] = s_q.irq;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.csr_rdata = '0;
    s_d.resp_rdata = '0;

    // control agent reads
    if (csr_read)
    begin
      unique case (csr_address)
        CSR_STATUS_OFS: s_d.csr_rdata = status_word;
        CSR_CONTROL_OFS:
        begin
          // reserved bits stay zero
          s_d.csr_rdata[CTRL_W-1:0] = s_q.ctrl;
          s_d.csr_rdata[CTRL_RESET] = s_q.resetting;
        end
        CSR_FILL_OFS:
        begin
          s_d.csr_rdata[FILL_RD_LSB +: FILL_W] = rdq.count;
          s_d.csr_rdata[FILL_WR_LSB +: FILL_W] = wrq.count;
        end
        default: s_d.csr_rdata = '0;
      endcase
    end

    // response agent reads; an empty queue reads as zero
    if (resp_read && !rspq.empty)
    begin
      if (resp_address == RESP_BYTES_OFS)
      begin
        s_d.resp_rdata = rspq.rdata[LEN_W-1:0];
      end
      else if (resp_address == RESP_ERR_OFS)
      begin
        s_d.resp_rdata[ERR_W-1:0] = rspq.rdata[LEN_W +: ERR_W];
        s_d.resp_rdata[RESP_ET_BIT] = rspq.rdata[RESP_W-1];
      end
    end

    // control writes; clearing stop bits resumes issue
    if (csr_write && csr_address == CSR_CONTROL_OFS)
    begin
      s_d.ctrl = csr_writedata[CTRL_W-1:0];
      s_d.ctrl[CTRL_RESET] = 1'b0;
      if (!csr_writedata[CTRL_STOP_ERR])
      begin
        s_d.err_stop = 1'b0;
      end
      if (!csr_writedata[CTRL_STOP_ET])
      begin
        s_d.et_stop = 1'b0;
      end
    end

    // write-one-to-clear of the latched interrupt
    if (csr_write && csr_address == CSR_STATUS_OFS && csr_writedata[ST_IRQ])
    begin
      s_d.irq = 1'b0;
    end

    // command hand-off remembers the running write descriptor
    if (wrq.pop)
    begin
      s_d.cur_len = wrq.rdata[LEN_W-1:0];
      s_d.cur_wait = wrq.rdata[LEN_W];
    end

    // accumulate until the transfer completes
    if (beat)
    begin
      s_d.bcnt = resp_done ? '0 : cnt_next;
      s_d.errs = resp_done ? '0 : errs_next;
      if (s_q.ctrl[CTRL_STOP_ERR] && snk_error != '0)
      begin
        s_d.err_stop = 1'b1;
      end
      if (s_q.ctrl[CTRL_STOP_ET] && resp_done && resp_et)
      begin
        s_d.et_stop = 1'b1;
      end
    end

    // masked events are never latched; a set beats a clear
    if (s_q.ctrl[CTRL_IRQ_EN] && resp_done)
    begin
      s_d.irq = 1'b1;
    end

    // software reset: flush and hold until hosts drain
    if (s_q.resetting)
    begin
      s_d.bcnt = '0;
      s_d.errs = '0;
      s_d.err_stop = 1'b0;
      s_d.et_stop = 1'b0;
      s_d.cur_wait = 1'b0;
      if (hosts_idle)
      begin
        s_d.resetting = 1'b0;
      end
    end
    if (csr_write && csr_address == CSR_CONTROL_OFS && csr_writedata[CTRL_RESET])
    begin
      s_d.resetting = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET_VAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : sgdc_dispatcher

// ===== design/sgdc_fifo.sv
// Purpose: small flip-flop queue used for commands and responses
// Assumes: DEPTH of two or more
// Notes: clear empties the queue without touching stored words

`timescale 1ns/100ps

module sgdc_fifo
  import sgdc_pkg::*;
#(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // queue port
  sgdc_fifo_if.store f
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } sgdc_fifo_state_t;

  sgdc_fifo_state_t s_q;
  sgdc_fifo_state_t s_d;
  logic do_push;
  logic do_pop;

  assign f.full = (s_q.cnt == FULL_CNT);
  assign f.empty = (s_q.cnt == '0);
  assign f.rdata = s_q.mem[s_q.rd];
  assign f.count = FILL_W'(s_q.cnt);
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;

  always_comb
  begin
    s_d = s_q;
    if (f.clear)
    begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.cnt = '0;
    end
    else
    begin
      if (do_push)
      begin
        s_d.mem[s_q.wr] = f.wdata;
        s_d.wr = (s_q.wr == LAST) ? '0 : AW'(s_q.wr + 1'b1);
      end
      if (do_pop)
      begin
        s_d.rd = (s_q.rd == LAST) ? '0 : AW'(s_q.rd + 1'b1);
      end
      if (do_push && !do_pop)
      begin
        s_d.cnt = CW'(s_q.cnt + 1'b1);
      end
      else if (do_pop && !do_push)
      begin
        s_d.cnt = CW'(s_q.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : sgdc_fifo

// ===== design/sgdc_fifo_if.sv
// Purpose: carrier between the dispatcher and one of its queues
// Assumes: owner and store share clk
// Notes: count is the number of stored entries

`timescale 1ns/100ps

interface sgdc_fifo_if #(parameter int unsigned W = 32);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic clear;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [sgdc_pkg::FILL_W-1:0] count;

  modport owner (output push, wdata, pop, clear, input rdata, full, empty, count);
  modport store (input push, wdata, pop, clear, output rdata, full, empty, count);
endinterface : sgdc_fifo_if

// ===== design/sgdc_pkg.sv
// Purpose: shared constants of the dispatcher control and response block
// Assumes: one clock, 32-bit agent data
// Notes: control and response offsets are byte addresses

package sgdc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W = 32;
  localparam int unsigned ERR_W = 8;
  localparam int unsigned FILL_W = 16;
  localparam int unsigned CTRL_W = 6;
  localparam int unsigned RESP_W = LEN_W + ERR_W + 1;

  // ****************************************
  // control agent offsets
  // ****************************************
  localparam logic [3:0] CSR_STATUS_OFS = 4'h0;
  localparam logic [3:0] CSR_CONTROL_OFS = 4'h4;
  localparam logic [3:0] CSR_FILL_OFS = 4'h8;

  // ****************************************
  // response agent offsets
  // ****************************************
  localparam logic [2:0] RESP_BYTES_OFS = 3'h0;
  localparam logic [2:0] RESP_ERR_OFS = 3'h4;
  localparam int unsigned RESP_POP_LANE = 3;
  localparam int unsigned RESP_ET_BIT = 8;

  // ****************************************
  // control bits
  // ****************************************
  localparam int unsigned CTRL_STOP = 0;
  localparam int unsigned CTRL_RESET = 1;
  localparam int unsigned CTRL_STOP_ERR = 2;
  localparam int unsigned CTRL_STOP_ET = 3;
  localparam int unsigned CTRL_IRQ_EN = 4;
  localparam int unsigned CTRL_STOP_DESC = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 6'h00;

  // ****************************************
  // status bits
  // ****************************************
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DESC_EMPTY = 1;
  localparam int unsigned ST_DESC_FULL = 2;
  localparam int unsigned ST_RESP_EMPTY = 3;
  localparam int unsigned ST_RESP_FULL = 4;
  localparam int unsigned ST_STOPPED = 5;
  localparam int unsigned ST_RESETTING = 6;
  localparam int unsigned ST_STOP_ERR = 7;
  localparam int unsigned ST_STOP_ET = 8;
  localparam int unsigned ST_IRQ = 9;

  // ****************************************
  // fill register fields
  // ****************************************
  localparam int unsigned FILL_RD_LSB = 0;
  localparam int unsigned FILL_WR_LSB = 16;

endpackage : sgdc_pkg

// ===== verification/sgdc_checker.sv
// Purpose: port-level checks of the dispatcher control and response block
// Assumes: one clock domain
// Notes: attached by bind

`timescale 1ns/100ps

module sgdc_checker
  import sgdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // agents
  input wire logic [3:0] csr_address,
  input wire logic csr_read,
  input wire logic csr_write,
  input wire logic [DATA_W-1:0] csr_writedata,
  input wire logic [DATA_W-1:0] csr_readdata,
  input wire logic resp_read,
  input wire logic [DATA_W-1:0] resp_readdata,
  // hosts and sink
  input wire logic desc_ready,
  input wire logic rd_cmd_valid,
  input wire logic wr_cmd_valid,
  input wire logic rd_busy,
  input wire logic wr_busy,
  input wire logic wr_resp_pending,
  input wire logic snk_valid,
  input wire logic snk_ready,
  input wire logic hosts_reset,
  input wire logic irq
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ctl_wr;
    csr_write && csr_address == CSR_CONTROL_OFS;
  endsequence
  sequence hosts_active;
    rd_busy || wr_busy || wr_resp_pending;
  endsequence
  stop_halts_issue_a: assert property (
    ctl_wr ##0 (csr_writedata[CTRL_STOP] || csr_writedata[CTRL_STOP_DESC])
    |=> !rd_cmd_valid && !wr_cmd_valid) else $error("issue after stop");
  reset_starts_a: assert property (ctl_wr ##0 csr_writedata[CTRL_RESET]
    |=> hosts_reset) else $error("reset cycle not started");
  reset_waits_a: assert property (hosts_reset ##0 hosts_active
    |=> hosts_reset) else $error("reset ended with hosts active");
  reset_blocks_a: assert property (hosts_reset
    |-> !desc_ready && !rd_cmd_valid && !wr_cmd_valid) else $error("traffic in reset");
  irq_cause_a: assert property ($rose(irq)
    |-> $past(snk_valid && snk_ready)) else $error("irq without event");
  csr_idle_zero_a: assert property (!csr_read
    |=> csr_readdata == '0) else $error("control readdata not zero");
  resp_idle_zero_a: assert property (!resp_read
    |=> resp_readdata == '0) else $error("response readdata not zero");
  unmapped_zero_a: assert property (csr_read && csr_address == 4'hc
    |=> csr_readdata == '0) else $error("unmapped read not zero");
endmodule : sgdc_checker

bind sgdc_dispatcher sgdc_checker u_sgdc_checker (.clk, .arst_n, .csr_address,
  .csr_read, .csr_write, .csr_writedata, .csr_readdata, .resp_read, .resp_readdata,
  .desc_ready, .rd_cmd_valid, .wr_cmd_valid, .rd_busy, .wr_busy, .wr_resp_pending,
  .snk_valid, .snk_ready, .hosts_reset, .irq);

// ===== verification/sgdc_host_model.sv
// Purpose: read and write hosts behind the dispatcher
// Assumes: a host takes a command only when idle
// Notes: write responses trail the write data phase

`timescale 1ns/100ps

module sgdc_host_model
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // read host
  input wire logic rd_cmd_valid,
  output logic rd_cmd_ready,
  output logic rd_busy,
  // write host
  input wire logic wr_cmd_valid,
  output logic wr_cmd_ready,
  output logic wr_busy,
  output logic wr_resp_pending
);
  logic [2:0] rd_cnt_q;
  logic [2:0] wr_cnt_q;
  assign rd_cmd_ready = (rd_cnt_q == 3'h0);
  assign wr_cmd_ready = (wr_cnt_q == 3'h0);
  assign rd_busy = (rd_cnt_q != 3'h0);
  assign wr_busy = (wr_cnt_q > 3'h2);
  assign wr_resp_pending = (wr_cnt_q != 3'h0) && (wr_cnt_q <= 3'h2);
  // in-flight transfers run to their end, also through a reset cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_cnt_q <= 3'h0;
      wr_cnt_q <= 3'h0;
    end
    else
    begin
      rd_cnt_q <= (rd_cmd_valid && rd_cmd_ready) ? 3'h7 : rd_cnt_q - {2'h0, rd_busy};
      wr_cnt_q <= (wr_cmd_valid && wr_cmd_ready) ? 3'h7 : wr_cnt_q - {2'h0, !wr_cmd_ready};
    end
  end
endmodule : sgdc_host_model

// ===== verification/tb.sv
// Purpose: self-checking bench of the dispatcher control and response block
// Assumes: response queue of two entries
// Notes: hosts come from the host model

`timescale 1ns/100ps

module tb;
  import sgdc_pkg::*;
  logic clk, arst_n, csr_read, csr_write, resp_read, desc_valid, snk_valid, snk_sop, snk_eop;
  logic [3:0] csr_address, resp_be;
  logic [2:0] resp_address, snk_bytes;
  logic [31:0] csr_writedata, csr_readdata, resp_readdata, desc_length, rd_cmd_length;
  logic [31:0] wr_cmd_length;
  logic [7:0] snk_error;
  logic desc_ready, rd_cmd_valid, rd_cmd_ready, rd_busy, wr_cmd_valid, wr_cmd_ready;
  logic wr_busy, wr_resp_pending, hosts_reset, irq;
  int mismatches, checked;

  sgdc_dispatcher #(.RESP_DEPTH(2)) u_sgdc_dispatcher (.clk, .arst_n, .csr_address,
    .csr_read, .csr_write, .csr_writedata, .csr_readdata, .resp_address, .resp_read,
    .resp_byteenable(resp_be), .resp_readdata, .desc_valid, .desc_ready, .desc_length,
    .desc_wait_resp(1'b1), .rd_cmd_valid, .rd_cmd_ready, .rd_cmd_length, .rd_busy,
    .wr_cmd_valid, .wr_cmd_ready, .wr_cmd_length, .wr_busy, .wr_resp_pending, .snk_valid,
    .snk_ready(1'b1), .snk_sop, .snk_eop, .snk_bytes, .snk_error, .hosts_reset, .irq);
  sgdc_host_model u_sgdc_host_model (.clk, .arst_n, .rd_cmd_valid, .rd_cmd_ready,
    .rd_busy, .wr_cmd_valid, .wr_cmd_ready, .wr_busy, .wr_resp_pending);

  // ****************************************
  // bus tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task cw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    csr_write <= 1'b1;
    csr_address <= a;
    csr_writedata <= d;
    @(posedge clk);
    csr_write <= 1'b0;
  endtask : cw
  task cr(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    csr_read <= 1'b1;
    csr_address <= a;
    @(posedge clk);
    csr_read <= 1'b0;
    #1 chk(csr_readdata & m, e);
  endtask : cr
  task rr(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk);
    resp_read <= 1'b1;
    resp_address <= a;
    @(posedge clk);
    resp_read <= 1'b0;
    #1 chk(resp_readdata, e);
  endtask : rr
  task dsc(input logic [31:0] len);
    @(posedge clk);
    desc_valid <= 1'b1;
    desc_length <= len;
    @(posedge clk);
    desc_valid <= 1'b0;
  endtask : dsc
  task bt(input logic s, input logic e, input logic [2:0] n, input logic [7:0] er);
    @(posedge clk);
    snk_valid <= 1'b1;
    snk_sop <= s;
    snk_eop <= e;
    snk_bytes <= n;
    snk_error <= er;
    @(posedge clk);
    snk_valid <= 1'b0;
  endtask : bt
  task done(input string n);
    $display("test %s done", n);
  endtask : done

  // ****************************************
  // scenarios
  // ****************************************
  task t_boot;
    cr(CSR_STATUS_OFS, 32'hffffffff, 32'h0000000a);
    cr(4'hc, 32'hffffffff, 32'h0);
    cw(CSR_CONTROL_OFS, 32'hffffffc0);
    cr(CSR_CONTROL_OFS, 32'hffffffff, 32'h0);
    dsc(32'd100);
    w(1);
    cr(CSR_STATUS_OFS, 32'h1, 32'h1);
    w(12);
    cr(CSR_STATUS_OFS, 32'h1, 32'h0);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h0);
    done("boot");
  endtask : t_boot
  task t_pkt;
    cw(CSR_CONTROL_OFS, 32'h10);
    dsc(32'd100);
    w(8);
    bt(1'b1, 1'b0, 3'h4, 8'h00);
    bt(1'b0, 1'b0, 3'h4, 8'h02);
    bt(1'b0, 1'b1, 3'h3, 8'h00);
    w(1);
    chk({31'h0, irq}, 32'h1);
    rr(RESP_BYTES_OFS, 32'd11);
    @(posedge clk) resp_be <= 4'h7;
    rr(RESP_ERR_OFS, 32'h02);
    cr(CSR_STATUS_OFS, 32'h8, 32'h0);
    @(posedge clk) resp_be <= 4'hf;
    rr(RESP_ERR_OFS, 32'h02);
    cr(CSR_STATUS_OFS, 32'h8, 32'h8);
    cw(CSR_STATUS_OFS, 32'h200);
    w(1);
    chk({31'h0, irq}, 32'h0);
    done("packet");
  endtask : t_pkt
  task t_et;
    cw(CSR_CONTROL_OFS, 32'h08);
    dsc(32'd6);
    w(8);
    bt(1'b1, 1'b0, 3'h4, 8'h00);
    bt(1'b0, 1'b0, 3'h4, 8'h00);
    w(8);
    chk({31'h0, irq}, 32'h0);
    cr(CSR_STATUS_OFS, 32'h120, 32'h120);
    rr(RESP_BYTES_OFS, 32'd8);
    rr(RESP_ERR_OFS, 32'h100);
    dsc(32'd6);
    w(2);
    chk({31'h0, rd_cmd_valid}, 32'h0);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h00010001);
    cw(CSR_CONTROL_OFS, 32'h0);
    w(10);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h0);
    done("early_term");
  endtask : t_et
  task t_err;
    cw(CSR_CONTROL_OFS, 32'h04);
    dsc(32'd100);
    w(8);
    bt(1'b1, 1'b1, 3'h2, 8'h81);
    w(8);
    cr(CSR_STATUS_OFS, 32'ha0, 32'ha0);
    rr(RESP_BYTES_OFS, 32'd2);
    rr(RESP_ERR_OFS, 32'h81);
    cw(CSR_CONTROL_OFS, 32'h0);
    cr(CSR_STATUS_OFS, 32'ha0, 32'h0);
    done("error");
  endtask : t_err
  task t_full;
    repeat (2)
    begin
      dsc(32'd100);
      w(8);
      bt(1'b1, 1'b1, 3'h1, 8'h00);
    end
    cr(CSR_STATUS_OFS, 32'h10, 32'h10);
    dsc(32'd100);
    w(2);
    chk({31'h0, rd_cmd_valid}, 32'h0);
    repeat (2)
    begin
      rr(RESP_BYTES_OFS, 32'd1);
      rr(RESP_ERR_OFS, 32'h0);
    end
    w(10);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h0);
    done("full");
  endtask : t_full
  task t_rst;
    dsc(32'd100);
    dsc(32'd100);
    cw(CSR_CONTROL_OFS, 32'h02);
    cr(CSR_STATUS_OFS, 32'h40, 32'h40);
    chk({31'h0, desc_ready}, 32'h0);
    repeat (30)
      if (hosts_reset !== 1'b0) w(1);
    cr(CSR_STATUS_OFS, 32'h40, 32'h0);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h0);
    cr(CSR_STATUS_OFS, 32'h3, 32'h2);
    done("sw_reset");
  endtask : t_rst
  task t_stop;
    dsc(32'd100);
    w(1);
    cw(CSR_CONTROL_OFS, 32'h01);
    cr(CSR_STATUS_OFS, 32'h20, 32'h0);
    w(8);
    cr(CSR_STATUS_OFS, 32'h20, 32'h20);
    dsc(32'd40);
    w(2);
    chk({31'h0, rd_cmd_valid}, 32'h0);
    chk(rd_cmd_length, 32'd40);
    chk(wr_cmd_length, 32'd40);
    cw(CSR_CONTROL_OFS, 32'h20);
    cr(CSR_STATUS_OFS, 32'h20, 32'h20);
    cw(CSR_CONTROL_OFS, 32'h0);
    w(10);
    cr(CSR_FILL_OFS, 32'hffffffff, 32'h0);
    done("stop");
  endtask : t_stop

  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    {csr_read, csr_write, resp_read, desc_valid, snk_valid, snk_sop, snk_eop} = '0;
    {csr_address, resp_address, snk_bytes, snk_error} = '0;
    resp_be = 4'hf;
    {csr_writedata, desc_length} = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_boot;
    t_pkt;
    t_et;
    t_err;
    t_full;
    t_rst;
    t_stop;
    report_and_stop;
  end
endmodule : tb
